// File: p1g_pin_model.sv
// Model of the port 1 pins: outside drivers, pull-ups and floating lines.
// Assumes the bench only drives pins that the port leaves as inputs.
`timescale 1ns/1ns
`default_nettype none
module p1g_pin_model
(
    input wire logic clk,
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe,
    input wire logic [7:0] pullup_on,
    input wire logic [7:0] ext_val,
    input wire logic [7:0] ext_en,
    output logic [7:0] pin_level
);
    logic [7:0] float_val = 8'h00;
    // A bare floating pin toggles, so a stale level never passes for a real one.
    always_ff @(posedge clk)
        float_val <= ~float_val;
    // Port drive wins, then the outside driver, then the pull-up.
    always_comb
        for (int i = 0; i < 8; i++)
            pin_level[i] = pin_oe[i] ? pin_out[i] : ext_en[i] ? ext_val[i] :
                pullup_on[i] ? 1'b1 : float_val[i];
endmodule // p1g_pin_model
`default_nettype wire

// File: p1g_pkg.sv
// Constants for the port 1 GPIO block with PWM pin remapping.
// Assumes a plain register port (address, strobes, read data one cycle later) on one clock.

package p1g_pkg;

    localparam int P1G_WIDTH = 8;
    localparam int P1G_ADDR_W = 4;

    // Register byte offsets.
    localparam logic [3:0] P1G_OFS_DATA = 4'h0;
    localparam logic [3:0] P1G_OFS_DIR = 4'h4;
    localparam logic [3:0] P1G_OFS_PULLUP = 4'h8;
    localparam logic [3:0] P1G_OFS_SYSCFG = 4'hC;

    // Field positions inside the system configuration register.
    localparam int P1G_SYSCFG_PWMSEL_BIT = 0;
    localparam int P1G_SYSCFG_PINSTATE_BIT = 1;

    // Reset values.
    localparam logic [7:0] P1G_RST_DATA = 8'h00;
    localparam logic [7:0] P1G_RST_DIR = 8'h00;
    localparam logic [7:0] P1G_RST_PULLUP = 8'h00;
    localparam logic [7:0] P1G_RST_SYSCFG = 8'h00;

    // Pin without a pull-up resistor.
    localparam int P1G_NO_PULLUP_PIN = 2;
    // Pins built as open-drain; none on this port by default.
    localparam logic [7:0] P1G_OPEN_DRAIN_MASK = 8'h00;

    // Port 1 bit index for each PWM output, order a0,b0,a1,b1,a2,b2.
    localparam int P1G_PWM_P1_BIT [6] = '{3, 4, 0, 1, 5, 6};
    // First port 6 bit used when the PWM outputs are remapped.
    localparam int P1G_PWM_P6_BASE = 2;

    // Standby pin handling mode.
    typedef enum logic [1:0] {
        P1G_PIN_RUN = 2'b01,
        P1G_PIN_ISOLATED = 2'b10
    } p1g_pin_mode_t;

endpackage

// File: p1g_port1_gpio.sv
// Port 1 GPIO with data latch, direction, pull-up, standby isolation and PWM remap.
// Assumes pin inputs are synchronous to clk and a plain register port master.
// Pins follow a register write two edges later; all outputs are registered.
`timescale 1ns/1ns
`default_nettype none

module p1g_port1_gpio
(
    input wire logic clk,
    input wire logic sys_rst,
    // Register port.
    input wire logic [p1g_pkg::P1G_ADDR_W-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic reg_rmw,
    output logic [7:0] reg_rdata,
    // Standby entry: high while the device sits in stop or watch mode.
    input wire logic standby_active,
    // PWM generator outputs, order a0,b0,a1,b1,a2,b2.
    input wire logic pwm0_out_a,
    input wire logic pwm0_out_b,
    input wire logic pwm1_out_a,
    input wire logic pwm1_out_b,
    input wire logic pwm2_out_a,
    input wire logic pwm2_out_b,
    input wire logic [5:0] pwm_oe,
    // Port 1 pins.
    input wire logic [7:0] port1_pin_in,
    output logic [7:0] port1_pin_out,
    output logic [7:0] port1_pin_oe,
    output logic [7:0] port1_pullup_on,
    // Pin level as seen by on-chip peripherals.
    output logic [7:0] port1_periph_in,
    // PWM drive for port 6 when remapped.
    output logic [7:0] port6_pwm_out,
    output logic [7:0] port6_pwm_oe,
    // Standby pin-state bit, for the port 6 block.
    output logic standby_pin_state
);
    import p1g_pkg::*;

    logic [7:0] port1_data_latch;
    logic [7:0] port1_direction;
    logic [7:0] port1_pullup_enable;
    logic pwm_pin_select;
    logic stby_pin_bit;
    logic [7:0] p1_per_out;
    logic [7:0] p1_per_oe;
    logic [7:0] p6_per_out;
    logic [7:0] p6_per_oe;
    logic [7:0] next_out;
    logic [7:0] next_oe;
    logic [7:0] next_pullup;
    logic [7:0] pin_seen;
    logic [7:0] next_rdata;
    p1g_pin_mode_t pin_mode;

    // Bit n of the data, direction and pull-up registers steers pin n; writes hit one register by address.
    function automatic logic hit(input logic [3:0] a, input logic [3:0] ofs);
        hit = (a == ofs);
    endfunction

    // Isolation is decoded in several places; the input path and port 6 drive share one function, the drive case decodes pin_mode itself.
    function automatic logic pins_isolated(input p1g_pin_mode_t m);
        pins_isolated = (m == P1G_PIN_ISOLATED);
    endfunction

    // The router places the six PWM outputs on one of the two ports.
    p1g_pwm_route p1g_pwm_route_i
    (
        .pwm_pin_select(pwm_pin_select),
        .pwm_out({pwm2_out_b, pwm2_out_a, pwm1_out_b, pwm1_out_a, pwm0_out_b, pwm0_out_a}),
        .pwm_oe(pwm_oe),
        .port1_periph_out(p1_per_out),
        .port1_periph_oe(p1_per_oe),
        .port6_periph_out(p6_per_out),
        .port6_periph_oe(p6_per_oe)
    );

    // Data latch: every write lands here regardless of direction.
    // Input pins keep the written value ready for a later switch to output.
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            port1_data_latch <= P1G_RST_DATA;
        else if (reg_write && hit(reg_addr, P1G_OFS_DATA))
            port1_data_latch <= reg_wdata;
    end

    // Direction register; cleared on reset so pins come up as inputs.
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            port1_direction <= P1G_RST_DIR;
        else if (reg_write && hit(reg_addr, P1G_OFS_DIR))
            port1_direction <= reg_wdata;
    end

    // Pull-up enable; bit 2 is stored though that pin has no resistor.
    // Software reads back what it wrote, which keeps driver code simple.
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            port1_pullup_enable <= P1G_RST_PULLUP;
        else if (reg_write && hit(reg_addr, P1G_OFS_PULLUP))
            port1_pullup_enable <= reg_wdata;
    end

    // PWM pin select. Switching it while a generator runs moves the waveform
    // in mid-period; software should stop the generator first.
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            pwm_pin_select <= P1G_RST_SYSCFG[P1G_SYSCFG_PWMSEL_BIT];
        else if (reg_write && hit(reg_addr, P1G_OFS_SYSCFG))
            pwm_pin_select <= reg_wdata[P1G_SYSCFG_PWMSEL_BIT];
    end

    // Standby pin-state bit; it only takes effect once standby is entered.
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            stby_pin_bit <= P1G_RST_SYSCFG[P1G_SYSCFG_PINSTATE_BIT];
        else if (reg_write && hit(reg_addr, P1G_OFS_SYSCFG))
            stby_pin_bit <= reg_wdata[P1G_SYSCFG_PINSTATE_BIT];
    end

    // Pin mode follows standby entry; only the pin-state bit isolates the pins.
    // Isolation starts one edge after entry and the pins float one edge later.
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            pin_mode <= P1G_PIN_RUN;
        else if (standby_active && stby_pin_bit)
            pin_mode <= P1G_PIN_ISOLATED;
        else
            pin_mode <= P1G_PIN_RUN;
    end

    // Drive selection. Peripheral enable wins over the port so a forgotten
    // peripheral still owns the pin; software is expected to avoid that case.
    // Pin 2 never gets a pull-up, whatever its enable bit holds.
    always_comb
    begin
        next_out = 8'h00;
        next_oe = 8'h00;
        next_pullup = 8'h00;
        for (int i = 0; i < P1G_WIDTH; i++)
        begin
            if (p1_per_oe[i])
            begin
                next_out[i] = p1_per_out[i];
                next_oe[i] = 1'b1;
            end
            else if (port1_direction[i])
            begin
                next_out[i] = port1_data_latch[i];
                next_oe[i] = 1'b1;
            end
            else
            begin
                next_out[i] = 1'b0;
                next_oe[i] = 1'b0;
            end
            // Open-drain pins cannot drive a one, they float instead.
            // The mask is a build constant, so the unused branch folds away.
            if (P1G_OPEN_DRAIN_MASK[i] && next_out[i])
                next_oe[i] = 1'b0;
            next_pullup[i] = port1_pullup_enable[i];
            if (next_oe[i] && !next_out[i])
                next_pullup[i] = 1'b0;
            if (i == P1G_NO_PULLUP_PIN)
                next_pullup[i] = 1'b0;
        end
        // Isolation floats everything; without it the selected drive passes through unchanged.
        case (pin_mode)
            P1G_PIN_ISOLATED:
            begin
                next_oe = 8'h00;
                next_out = 8'h00;
                next_pullup = 8'h00;
            end
            P1G_PIN_RUN:
            begin
                next_oe = next_oe;
            end
            default:
            begin
                // Unused codes float the pins, the safe side for an illegal state.
                next_oe = 8'h00;
            end
        endcase
    end

    // Input path: isolated pins read low to avoid floating-input leakage.
    always_comb
    begin
        if (pins_isolated(pin_mode))
            pin_seen = 8'h00;
        else
            pin_seen = port1_pin_in;
    end

    // Read mux. Output pins that no peripheral drives show the latch, everything else the pin;
    // a read-modify-write read always shows the latch.
    // The answer is registered, so a read never stalls the master.
    always_comb
    begin
        next_rdata = 8'h00;
        case (reg_addr)
            P1G_OFS_DATA:
            begin
                for (int i = 0; i < P1G_WIDTH; i++)
                begin
                    if (reg_rmw)
                        next_rdata[i] = port1_data_latch[i];
                    else if (port1_direction[i] && !p1_per_oe[i])
                        next_rdata[i] = port1_data_latch[i];
                    else
                        next_rdata[i] = pin_seen[i];
                end
            end
            P1G_OFS_DIR:
                next_rdata = port1_direction;
            P1G_OFS_PULLUP:
                next_rdata = port1_pullup_enable;
            P1G_OFS_SYSCFG:
            begin
                next_rdata[P1G_SYSCFG_PWMSEL_BIT] = pwm_pin_select;
                next_rdata[P1G_SYSCFG_PINSTATE_BIT] = stby_pin_bit;
            end
            default:
                next_rdata = 8'h00;
        endcase
    end

    // Read data stands only in the cycle after the strobe.
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            reg_rdata <= 8'h00;
        else if (reg_read)
            reg_rdata <= next_rdata;
        else
            reg_rdata <= 8'h00;
    end

    // Registered pin drive; one cycle of latency keeps outputs glitch free.
    // The price is that a write reaches the pin two edges after its strobe.
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            port1_pin_out <= 8'h00;
            port1_pin_oe <= 8'h00;
            port1_pullup_on <= 8'h00;
        end
        else
        begin
            port1_pin_out <= next_out;
            port1_pin_oe <= next_oe;
            port1_pullup_on <= next_pullup;
        end
    end

    // Pin levels handed to the peripherals. Isolated pins are forced low
    // upstream, so a floating line cannot toggle a peripheral input.
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            port1_periph_in <= 8'h00;
        else
            port1_periph_in <= pin_seen;
    end

    // Port 6 PWM drive, also floated by standby isolation.
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            port6_pwm_out <= 8'h00;
            port6_pwm_oe <= 8'h00;
        end
        else
        begin
            port6_pwm_out <= p6_per_out;
            if (pins_isolated(pin_mode))
                port6_pwm_oe <= 8'h00;
            else
                port6_pwm_oe <= p6_per_oe;
        end
    end

    // Copy of the pin-state bit for the port 6 block, which applies
    // its own isolation to the pins that it owns.
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            standby_pin_state <= 1'b0;
        else
            standby_pin_state <= stby_pin_bit;
    end

endmodule // p1g_port1_gpio

`default_nettype wire

// File: p1g_port1_gpio_properties.sv
// Checker for the port 1 GPIO block, bound to its top module.
// Assumes one clock domain and the package register offsets.
`timescale 1ns/1ns
`default_nettype none
module p1g_port1_gpio_chk
    import p1g_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [p1g_pkg::P1G_ADDR_W-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic reg_rmw,
    input wire logic [7:0] reg_rdata,
    input wire logic standby_active,
    input wire logic pwm0_out_a,
    input wire logic [5:0] pwm_oe,
    input wire logic [7:0] port1_pin_out,
    input wire logic [7:0] port1_pin_oe,
    input wire logic [7:0] port1_pullup_on,
    input wire logic [7:0] port1_periph_in,
    input wire logic [7:0] port6_pwm_out,
    input wire logic [7:0] port6_pwm_oe,
    input wire logic standby_pin_state
);
    logic [7:0] latch;
    logic [7:0] dir;
    logic sel;
    // Shadow registers, so pin checks never look inside the design.
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            latch <= 8'h00;
            dir <= 8'h00;
            sel <= 1'b0;
        end
        else if (reg_write)
        begin
            if (reg_addr == P1G_OFS_DATA) latch <= reg_wdata;
            if (reg_addr == P1G_OFS_DIR) dir <= reg_wdata;
            if (reg_addr == P1G_OFS_SYSCFG) sel <= reg_wdata[P1G_SYSCFG_PWMSEL_BIT];
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    // Three quiet cycles let the two-stage pin path settle.
    sequence s_plain;
        (pwm_oe == 6'h00 && !standby_active)[*3];
    endsequence
    property p_rmw;
        reg_read && reg_rmw && reg_addr == P1G_OFS_DATA |=> reg_rdata == $past(latch);
    endproperty
    a_rmw: assert property (p_rmw) else $error("rmw read not latch");
    property p_dir_oe;
        s_plain |-> port1_pin_oe == $past(dir);
    endproperty
    a_dir_oe: assert property (p_dir_oe) else $error("drive not direction");
    property p_reset_dir;
        $past(sys_rst) |-> port1_pin_oe == 8'h00;
    endproperty
    a_reset_dir: assert property (p_reset_dir) else $error("drive after reset");
    property p_pull_low;
        (port1_pin_oe & ~port1_pin_out & port1_pullup_on) == 8'h00;
    endproperty
    a_pull_low: assert property (p_pull_low) else $error("pull-up on low pin");
    property p_pin2;
        !port1_pullup_on[P1G_NO_PULLUP_PIN];
    endproperty
    a_pin2: assert property (p_pin2) else $error("pull-up on pin 2");
    property p_iso;
        (standby_active && standby_pin_state)[*3] |=>
            port1_pin_oe == 8'h00 && port1_pullup_on == 8'h00 && port1_periph_in == 8'h00;
    endproperty
    a_iso: assert property (p_iso) else $error("pins not isolated");
    property p_sel0;
        (!sel && pwm_oe[0] && $stable(pwm0_out_a) && !standby_active)[*3] |->
            port1_pin_oe[3] && port1_pin_out[3] == pwm0_out_a;
    endproperty
    a_sel0: assert property (p_sel0) else $error("pwm not on port 1");
    property p_sel1;
        (sel && pwm_oe[0] && $stable(pwm0_out_a) && !standby_active)[*3] |->
            port6_pwm_oe[2] && port6_pwm_out[2] == pwm0_out_a;
    endproperty
    a_sel1: assert property (p_sel1) else $error("pwm not on port 6");
    c_rmw: cover property (reg_read && reg_rmw);
    c_iso: cover property (standby_active && standby_pin_state);
    c_sel1: cover property (sel && pwm_oe[0]);
endmodule // p1g_port1_gpio_chk
bind p1g_port1_gpio p1g_port1_gpio_chk p1g_port1_gpio_chk_i(.clk, .sys_rst, .reg_addr,
    .reg_wdata, .reg_write, .reg_read, .reg_rmw, .reg_rdata, .standby_active, .pwm0_out_a,
    .pwm_oe, .port1_pin_out, .port1_pin_oe, .port1_pullup_on, .port1_periph_in,
    .port6_pwm_out, .port6_pwm_oe, .standby_pin_state);
`default_nettype wire

// File: p1g_pwm_route.sv
// PWM output router between port 1 and port 6.
// Assumes the six PWM outputs and their enables are steady on the system clock.
`timescale 1ns/1ns
`default_nettype none

module p1g_pwm_route
(
    input wire logic pwm_pin_select,
    input wire logic [5:0] pwm_out,
    input wire logic [5:0] pwm_oe,
    output logic [7:0] port1_periph_out,
    output logic [7:0] port1_periph_oe,
    output logic [7:0] port6_periph_out,
    output logic [7:0] port6_periph_oe
);
    import p1g_pkg::*;

    // Each PWM output lands on exactly one port, so the unused one sees no enable.
    always_comb
    begin
        port1_periph_out = 8'h00;
        port1_periph_oe = 8'h00;
        port6_periph_out = 8'h00;
        port6_periph_oe = 8'h00;
        for (int i = 0; i < 6; i++)
        begin
            if (!pwm_pin_select)
            begin
                port1_periph_out[P1G_PWM_P1_BIT[i]] = pwm_out[i];
                port1_periph_oe[P1G_PWM_P1_BIT[i]] = pwm_oe[i];
            end
            else
            begin
                port6_periph_out[P1G_PWM_P6_BASE + i] = pwm_out[i];
                port6_periph_oe[P1G_PWM_P6_BASE + i] = pwm_oe[i];
            end
        end
    end

endmodule // p1g_pwm_route

`default_nettype wire

// File: test_p1g_port1_gpio.sv
// Self-checking bench for the port 1 GPIO block.
// Assumes the package offsets and a two-cycle write-to-pin path.
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin miscompares++; \
    $display("MISMATCH %s expected %h seen %h", n, e, g); end end
module test_p1g_port1_gpio;
    import p1g_pkg::*;
    logic clk, sys_rst, reg_write, reg_read, reg_rmw, standby_active, pin_state;
    logic [3:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, pin_in, pin_out, pin_oe, pullup_on, periph_in;
    logic [7:0] p6_out, p6_oe, ext_val, ext_en;
    logic [5:0] pwm_v, pwm_oe;
    int miscompares = 0;
    int compares = 0;
    int cycles = 0;
    p1g_port1_gpio p1g_port1_gpio_i(.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rmw(reg_rmw), .reg_rdata(reg_rdata), .standby_active(standby_active),
        .pwm0_out_a(pwm_v[0]), .pwm0_out_b(pwm_v[1]), .pwm1_out_a(pwm_v[2]),
        .pwm1_out_b(pwm_v[3]), .pwm2_out_a(pwm_v[4]), .pwm2_out_b(pwm_v[5]),
        .pwm_oe(pwm_oe), .port1_pin_in(pin_in), .port1_pin_out(pin_out),
        .port1_pin_oe(pin_oe), .port1_pullup_on(pullup_on), .port1_periph_in(periph_in),
        .port6_pwm_out(p6_out), .port6_pwm_oe(p6_oe), .standby_pin_state(pin_state));
    p1g_pin_model p1g_pin_model_i(.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe),
        .pullup_on(pullup_on), .ext_val(ext_val), .ext_en(ext_en), .pin_level(pin_in));
    // Free-running clock.
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task automatic complete_run;
        $display("Comparisons %0d, mismatches %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // A hang is cut short at 3000 cycles, well beyond the roughly 65 cycles the run needs.
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            miscompares++;
            complete_run();
        end
    end
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clk);
        reg_write <= 1'b0;
    endtask
    task automatic rdc(input logic [3:0] a, input logic m, input logic [7:0] e, string n);
        @(posedge clk);
        reg_addr <= a;
        reg_rmw <= m;
        reg_read <= 1'b1;
        @(posedge clk);
        reg_read <= 1'b0;
        reg_rmw <= 1'b0;
        #1;
        `CHK(n, e, reg_rdata)
    endtask
    task automatic settle;
        repeat (3) @(posedge clk);
        #1;
    endtask
    task automatic t_reset;
        settle();
        `CHK("oe", 8'h00, pin_oe)
        rdc(P1G_OFS_DIR, 1'b0, 8'h00, "dir");
        rdc(P1G_OFS_DATA, 1'b1, 8'h00, "latch");
        rdc(P1G_OFS_PULLUP, 1'b0, 8'h00, "pullup");
        rdc(4'h1, 1'b0, 8'h00, "unmapped");
    endtask
    task automatic t_port;
        wr(P1G_OFS_DATA, 8'hA5);
        wr(P1G_OFS_DIR, 8'h0F);
        settle();
        `CHK("oe", 8'h0F, pin_oe)
        `CHK("out", 8'h05, pin_out & 8'h0F)
        `CHK("in", 8'h65, periph_in)
        rdc(P1G_OFS_DATA, 1'b0, 8'h65, "read");
        rdc(P1G_OFS_DATA, 1'b1, 8'hA5, "rmw");
        wr(P1G_OFS_PULLUP, 8'hFF);
        settle();
        `CHK("pull", 8'hF1, pullup_on)
        rdc(P1G_OFS_PULLUP, 1'b0, 8'hFF, "pullreg");
    endtask
    task automatic t_pwm;
        @(posedge clk);
        ext_en <= 8'h80;
        pwm_v <= 6'b101101;
        pwm_oe <= 6'h3F;
        settle();
        `CHK("oe", 8'h7F, pin_oe)
        `CHK("out", 8'h4B, pin_out & 8'h7B)
        rdc(P1G_OFS_DATA, 1'b0, 8'h4F, "pinread");
        rdc(P1G_OFS_DATA, 1'b1, 8'hA5, "rmw");
        wr(P1G_OFS_SYSCFG, 8'h01);
        settle();
        `CHK("p6oe", 8'hFC, p6_oe)
        `CHK("p6out", 8'hB4, p6_out)
        `CHK("oe", 8'h0F, pin_oe)
        @(posedge clk);
        pwm_oe <= 6'h00;
        wr(P1G_OFS_SYSCFG, 8'h00);
        ext_en <= 8'hF0;
    endtask
    task automatic t_standby;
        wr(P1G_OFS_SYSCFG, 8'h02);
        standby_active <= 1'b1;
        settle();
        `CHK("oe", 8'h00, pin_oe)
        `CHK("pull", 8'h00, pullup_on)
        `CHK("in", 8'h00, periph_in)
        `CHK("state", 1'b1, pin_state)
        rdc(P1G_OFS_DATA, 1'b0, 8'h05, "isoread");
        @(posedge clk);
        standby_active <= 1'b0;
        wr(P1G_OFS_SYSCFG, 8'h00);
        standby_active <= 1'b1;
        settle();
        `CHK("oe", 8'h0F, pin_oe)
        `CHK("out", 8'h05, pin_out & 8'h0F)
        @(posedge clk);
        standby_active <= 1'b0;
    endtask
    // Main sequence: reset for six cycles, then the scenarios in turn.
    initial
    begin
        sys_rst = 1'b1;
        {reg_write, reg_read, reg_rmw, standby_active} = 4'h0;
        reg_addr = 4'h0;
        reg_wdata = 8'h00;
        pwm_v = 6'h00;
        pwm_oe = 6'h00;
        ext_val = 8'h60;
        ext_en = 8'hF0;
        repeat (6) @(posedge clk);
        sys_rst <= 1'b0;
        t_reset();
        t_port();
        t_pwm();
        t_standby();
        complete_run();
    end
endmodule // test_p1g_port1_gpio
`default_nettype wire
